//--- logic/dcsp_pkg.sv
// Package of constants and types shared by the daisy-chain serial path ends
// ----------------------------------------------------------------------------
// Functional notes
// - Chain output active only with chain_enable high
// - Output released when frame high or disabled
// - Frame low ties last stage to output
// - Output is input delayed 24 clock cycles
// - One shared clock and frame for all
// - Each output feeds next device input
// - Host gives 24 times n clocks per frame
// - Rising frame updates every device together
// - Device acts on control bits it holds
// - Mixed chains need correct total bit count
// - Serial clock at most 10 MHz forwarding
// - Word 24 bits MSB first: 8+12+4
// - Bits sampled on falling clock, frame low
// - One falling edge after rising frame
// - Latest 24 bits before rising frame load; first 24 if chain_enable low, none on first chain frame after reset
// ----------------------------------------------------------------------------
package dcsp_pkg;
  localparam int WORD_BITS = 24;
  localparam int CTRL_MSB = 23;
  localparam int CTRL_LSB = 16;
  localparam int DATA_MSB = 15;
  localparam int DATA_LSB = 4;
  localparam int CNT_W = 5;
  localparam logic [WORD_BITS-1:0] SHIFT_RESET = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_LAST = 5'h17;
  // Serial clock half period in mclk cycles: 125 MHz / 14 stays under 10 MHz
  localparam logic [3:0] HALF_DIV_CNT = 4'h7;
  localparam logic [7:0] DEV_MAX = 8'h08;
  typedef logic [WORD_BITS-1:0] dcsp_word_t;
  typedef enum logic [2:0] {DCSP_IDLE, DCSP_LEAD, DCSP_SHIFT, DCSP_END, DCSP_INIT} dcsp_state_t;
endpackage : dcsp_pkg

//--- logic/dcsp_if.sv
// Interface joining the host controller and one chained device
`timescale 1ns/1ps
interface dcsp_if;
  logic sclk;
  logic sync_n;
  logic serial_bit_in;
  logic serial_forward_out;
  logic serial_forward_out_en_n;
  modport host (output sclk, output sync_n, output serial_bit_in, input serial_forward_out);
  modport device (input sclk, input sync_n, input serial_bit_in,
    output serial_forward_out, output serial_forward_out_en_n);
endinterface : dcsp_if

//--- logic/dcsp_device.sv
// Device end: 24-bit shift register, forwarding output and word load
`timescale 1ns/1ps
module dcsp_device
  import dcsp_pkg::*;
(
  input wire logic i_resetn,
  input wire logic i_chain_enable,
  dcsp_if.device link,
  output logic [dcsp_pkg::CTRL_MSB-dcsp_pkg::CTRL_LSB:0] o_ctrl,
  output logic [dcsp_pkg::DATA_MSB-dcsp_pkg::DATA_LSB:0] o_data,
  output logic o_update
);
  import dcsp_pkg::*;

  // --------------------------------------------------------------------------
  // Shift path on the link clock
  // --------------------------------------------------------------------------
  dcsp_word_t shreg;
  logic [CNT_W-1:0] count;
  logic arm_tog;
  logic load_tog;
  logic armed;

  // Re-armed while the toggles differ; each rising frame makes them equal
  assign armed = (arm_tog != load_tog);

  // Sample on falling serial clock while frame is low, MSB first
  always_ff @(negedge link.sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      shreg <= SHIFT_RESET;
    end else if (!link.sync_n && (i_chain_enable || count != CNT_LAST + 5'h01)) begin
      shreg <= {shreg[WORD_BITS-2:0], link.serial_bit_in};
    end
  end

  // Bit count; cleared while frame is high, holds at 24 in both modes
  always_ff @(negedge link.sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      count <= CNT_ZERO;
    end else if (link.sync_n) begin
      count <= CNT_ZERO;
    end else if (count <= CNT_LAST) begin
      count <= count + 5'h01;
    end
  end

  // Reinit edge: a falling clock with frame high re-arms the next load
  always_ff @(negedge link.sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      arm_tog <= 1'b0;
    end else if (link.sync_n) begin
      arm_tog <= ~load_tog;
    end
  end

  // --------------------------------------------------------------------------
  // Load on rising frame sync
  // --------------------------------------------------------------------------
  always_ff @(posedge link.sync_n or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ctrl <= '0;
      o_data <= '0;
      o_update <= 1'b0;
    end else if (count > CNT_LAST && (armed || !i_chain_enable)) begin
      o_ctrl <= shreg[CTRL_MSB:CTRL_LSB];
      o_data <= shreg[DATA_MSB:DATA_LSB];
      o_update <= ~o_update; // Toggles once per accepted word
    end
  end

  // Every rising frame spends the re-arm; the two edges are half periods apart
  always_ff @(posedge link.sync_n or negedge i_resetn) begin
    if (!i_resetn) begin
      load_tog <= 1'b0;
    end else begin
      load_tog <= arm_tog;
    end
  end

  // Last stage tied to the output; released when idle or disabled
  assign link.serial_forward_out = shreg[WORD_BITS-1];
  assign link.serial_forward_out_en_n = link.sync_n | ~i_chain_enable;
endmodule : dcsp_device

//--- logic/dcsp_host.sv
// Host end: divides its clock to make the serial clock and shifts a chain
`timescale 1ns/1ps
module dcsp_host
  import dcsp_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire logic [7:0] i_dev_count,
  input wire logic [dcsp_pkg::WORD_BITS-1:0] i_word,
  output logic o_word_req,
  output logic o_busy,
  output logic o_done,
  output logic [dcsp_pkg::WORD_BITS-1:0] o_returned,
  dcsp_if.host link
);
  import dcsp_pkg::*;

  dcsp_state_t state;
  logic [3:0] div;
  logic [CNT_W-1:0] bit_cnt;
  logic [7:0] dev_left;
  dcsp_word_t word;
  logic sclk;
  logic frame_n;
  logic ret_s1, ret_s2;
  logic tick;

  assign tick = (div == HALF_DIV_CNT - 4'h1);

  // Divider paced below 10 MHz
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      div <= 4'h0;
    end else if (tick || state == DCSP_IDLE) begin
      div <= 4'h0;
    end else begin
      div <= div + 4'h1;
    end
  end

  // Synchroniser for the returned chain bit
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ret_s1 <= 1'b0;
      ret_s2 <= 1'b0;
    end else begin
      ret_s1 <= link.serial_forward_out;
      ret_s2 <= ret_s1;
    end
  end

  // --------------------------------------------------------------------------
  // Frame sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= DCSP_IDLE;
      sclk <= 1'b1;
      frame_n <= 1'b1;
      bit_cnt <= CNT_ZERO;
      dev_left <= 8'h00;
      word <= SHIFT_RESET;
      o_returned <= SHIFT_RESET;
      o_done <= 1'b0;
      o_word_req <= 1'b0;
    end else begin
      o_done <= 1'b0;
      o_word_req <= 1'b0;
      unique case (state)
        DCSP_IDLE: begin
          sclk <= 1'b1;
          if (i_start && i_dev_count != 8'h00 && i_dev_count <= DEV_MAX) begin
            dev_left <= i_dev_count;
            word <= i_word;
            o_word_req <= 1'b1;
            bit_cnt <= CNT_ZERO;
            frame_n <= 1'b0;
            state <= DCSP_LEAD;
          end
        end
        DCSP_LEAD: if (tick) state <= DCSP_SHIFT;
        DCSP_SHIFT: if (tick) begin
          sclk <= ~sclk;
          if (sclk) begin
            // Falling edge: take the returned bit before the chain moves it
            o_returned <= {o_returned[WORD_BITS-2:0], ret_s2};
          end else begin
            // Rising edge: present next bit, MSB first
            word <= {word[WORD_BITS-2:0], 1'b0};
            if (bit_cnt == CNT_LAST) begin
              bit_cnt <= CNT_ZERO;
              if (dev_left == 8'h01) begin
                frame_n <= 1'b1;
                state <= DCSP_END;
              end else begin
                dev_left <= dev_left - 8'h01;
                word <= i_word;
                o_word_req <= 1'b1;
              end
            end else begin
              bit_cnt <= bit_cnt + 5'h01;
            end
          end
        end
        DCSP_END: if (tick) state <= DCSP_INIT;
        DCSP_INIT: if (tick) begin
          sclk <= ~sclk;
          if (!sclk) begin
            o_done <= 1'b1;
            state <= DCSP_IDLE;
          end
        end
        default: state <= DCSP_IDLE;
      endcase
    end
  end

  assign o_busy = (state != DCSP_IDLE);
  assign link.sclk = sclk;
  assign link.sync_n = frame_n; // Registered so the device never sees a decode glitch
  assign link.serial_bit_in = word[WORD_BITS-1];
endmodule : dcsp_host

//--- tb/dcsp_properties.sv
// Concurrent checks on the link between host and chained device
`timescale 1ns/1ps
module dcsp_properties (
  input logic i_mclk,
  input logic i_resetn,
  input logic i_chain_enable,
  input logic sclk,
  input logic sync_n,
  input logic serial_bit_in,
  input logic serial_forward_out,
  input logic serial_forward_out_en_n,
  input logic o_done
);
  logic sclk_q;
  logic [3:0] hcnt;
  logic [7:0] fcnt;
  logic [23:0] hist;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  // Half period length and falling edges per frame
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_q <= 1'b1;
      hcnt <= 4'hf;
      fcnt <= 8'h00;
    end else begin
      sclk_q <= sclk;
      hcnt <= (sclk != sclk_q) ? 4'h0 : ((hcnt == 4'hf) ? hcnt : hcnt + 4'h1);
      fcnt <= sync_n ? 8'h00 : ((sclk_q && !sclk) ? fcnt + 8'h01 : fcnt);
    end
  end
  // Bits taken in, as the device should see them
  always_ff @(negedge sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      hist <= 24'h000000;
    end else if (!sync_n) begin
      hist <= {hist[22:0], serial_bit_in};
    end
  end
  chk_out_released: assert property (
      (sync_n || !i_chain_enable) |-> serial_forward_out_en_n)
    else $error("output driven while released");
  chk_out_tied: assert property (
      (!sync_n && i_chain_enable) |-> !serial_forward_out_en_n)
    else $error("output not driven in frame");
  chk_out_steady: assert property (
      (sclk == $past(sclk) && !$past(serial_forward_out_en_n)) |-> $stable(serial_forward_out))
    else $error("output moved between clock edges");
  chk_fwd_delay: assert property (
      @(negedge sclk) disable iff (!i_resetn)
      (!sync_n && i_chain_enable) |-> serial_forward_out == hist[23])
    else $error("forwarded bit wrong");
  chk_frame_count: assert property ($rose(sync_n) |-> (fcnt == 8'h18 || fcnt == 8'h30))
    else $error("falls per frame wrong");
  chk_init_edge: assert property ($rose(sync_n) |-> ##[1:20] $fell(sclk))
    else $error("no falling edge after frame");
  chk_half_period: assert property ($changed(sclk) |-> hcnt >= 4'h6)
    else $error("serial clock too fast");
  chk_done_after: assert property ($rose(sync_n) |-> ##[8:40] o_done)
    else $error("no done after frame");
  cover property ($rose(sync_n) && fcnt == 8'h30);
  cover property (!serial_forward_out_en_n);
  cover property (!sync_n && !i_chain_enable);
endmodule : dcsp_properties

//--- tb/daisy_chain_serial_path_tb.sv
// Bench: host and one device joined by the link
`timescale 1ns/1ps
module daisy_chain_serial_path_tb;
  import dcsp_pkg::*;
  logic mclk, resetn, start, chain_en, word_req, busy, done, upd;
  logic [7:0] dev, ctrl;
  logic [11:0] data;
  dcsp_word_t word, returned;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  dcsp_if lnk();
  dcsp_host u_dcsp_host (.i_mclk(mclk), .i_resetn(resetn), .i_start(start), .i_dev_count(dev),
    .i_word(word), .o_word_req(word_req), .o_busy(busy), .o_done(done), .o_returned(returned),
    .link(lnk.host));
  dcsp_device u_dcsp_device (.i_resetn(resetn), .i_chain_enable(chain_en), .link(lnk.device),
    .o_ctrl(ctrl), .o_data(data), .o_update(upd));
  dcsp_properties props (.i_mclk(mclk), .i_resetn(resetn), .i_chain_enable(chain_en),
    .sclk(lnk.sclk), .sync_n(lnk.sync_n), .serial_bit_in(lnk.serial_bit_in),
    .serial_forward_out(lnk.serial_forward_out),
    .serial_forward_out_en_n(lnk.serial_forward_out_en_n), .o_done(done));
  // Compare and count
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // One frame; second word goes out after the first request
  task automatic frame(input dcsp_word_t w0, input dcsp_word_t w1, input logic [7:0] n);
    int i;
    word = w0;
    dev = n;
    @(negedge mclk) start = 1'b1;
    @(negedge mclk) start = 1'b0;
    for (i = 0; i < 50 && word_req !== 1'b1; i++) @(negedge mclk);
    check({23'h000000, word_req}, 24'h000001);
    check({23'h000000, busy}, 24'h000001);
    @(negedge mclk) word = w1;
    for (i = 0; i < 2000 && done !== 1'b1; i++) @(negedge mclk);
    check({23'h000000, done}, 24'h000001);
    check({23'h000000, busy}, 24'h000000);
  endtask : frame
  // Start with a device count of zero or above eight is ignored
  task automatic t_refuse();
    int i;
    int k;
    logic seen;
    seen = 1'b0;
    for (k = 0; k < 2; k++) begin
      dev = (k == 0) ? 8'h00 : 8'h09;
      @(negedge mclk) start = 1'b1;
      @(negedge mclk) start = 1'b0;
      for (i = 0; i < 20; i++) begin
        seen = seen | busy | word_req;
        @(negedge mclk);
      end
    end
    check({23'h000000, seen}, 24'h000000);
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_chain();
    logic u0;
    chain_en = 1'b1;
    frame(24'h0a5c31, 24'h0a5c31, 8'h01);
    frame(24'h3c7e96, 24'h3c7e96, 8'h01);
    check(returned, 24'h0a5c31);
    check(24'(ctrl), 24'h00003c);
    check(24'(data), 24'h0007e9);
    u0 = upd;
    frame(24'h25d0f7, 24'h25d0f7, 8'h01);
    check(returned, 24'h3c7e96);
    check({23'h000000, upd}, {23'h000000, ~u0});
    $display("test chain done");
  endtask : t_chain
  task automatic t_latest();
    frame(24'h1f00a0, 24'h2e4b80, 8'h02);
    check(24'(ctrl), 24'h00002e);
    check(24'(data), 24'h0004b8);
    check(returned, 24'h1f00a0);
    $display("test latest done");
  endtask : t_latest
  task automatic t_nochain();
    chain_en = 1'b0;
    frame(24'h11abc0, 24'h11abc0, 8'h01);
    check(24'(ctrl), 24'h000011);
    check(24'(data), 24'h000abc);
    frame(24'h5a3c10, 24'h6b4d20, 8'h02);
    check(24'(ctrl), 24'h00005a);
    check(24'(data), 24'h0003c1);
    $display("test nochain done");
  endtask : t_nochain
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  // Clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      complete_run();
    end
  end
  // Reset, then the scenarios
  initial begin
    resetn = 1'b0;
    start = 1'b0;
    chain_en = 1'b1;
    dev = 8'h01;
    word = 24'h000000;
    repeat (6) @(negedge mclk);
    resetn = 1'b1;
    t_chain();
    t_latest();
    t_refuse();
    t_nochain();
    complete_run();
  end
endmodule : daisy_chain_serial_path_tb
